// File: adpp_pkg.sv
package adpp_pkg;
  // Port widths and field positions of the parallel port.
  localparam int DATA_W     = 12;
  localparam int CHAN_W     = 3;
  localparam int BYTE_W     = 8;
  localparam int NIB_W      = 4;
  localparam int PAD10_W    = 2;
  localparam int HB_SEL_BIT = 8;
  localparam int CHAN_LSB   = 5;
  localparam int PM_HI_BIT  = 11;
  localparam int PM_LO_BIT  = 10;
  localparam int SHDW_BIT   = 3;
  localparam int CNT_W      = 4;
  localparam int CONV_EDGES = 13;
  localparam logic [DATA_W-1:0] CTRL_RST = 12'h000;

  // Power mode encodings of the two mode bits.
  localparam logic [1:0] PM_NORMAL  = 2'h0;
  localparam logic [1:0] PM_AUTO_SD = 2'h1;
  localparam logic [1:0] PM_AUTO_SB = 2'h2;
  localparam logic [1:0] PM_FULL_SD = 2'h3;

  // Power-up times in nanoseconds and their cycle counts at the system clock.
  localparam int     CLK_MHZ     = 50;
  localparam longint T_SD_UP_NS  = 10_000_000;
  localparam longint T_SB_EXT_NS = 600;
  localparam longint T_SB_INT_NS = 7000;
  localparam int     WAIT_W      = 20;

  // Least times round up to whole cycles.
  function automatic int ns_to_cyc(longint ns);
    return int'((ns * CLK_MHZ + 999) / 1000);
  endfunction

  localparam int SD_UP_CYC  = ns_to_cyc(T_SD_UP_NS);
  localparam int SB_EXT_CYC = ns_to_cyc(T_SB_EXT_NS);
  localparam int SB_INT_CYC = ns_to_cyc(T_SB_INT_NS);

  // Controller register map on APB.
  localparam logic [7:0] REG_CFG      = 8'h00;
  localparam logic [7:0] REG_CMD_WR   = 8'h04;
  localparam logic [7:0] REG_CMD_CONV = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0c;
  localparam logic [7:0] REG_RESULT   = 8'h10;
  localparam int CFG_WORD_BIT   = 0;
  localparam int CFG_INTREF_BIT = 1;
  localparam int CMD_SHDW_BIT   = 16;
  localparam int ST_SEQ_BIT     = 0;
  localparam int ST_BUSY_BIT    = 1;
  localparam int ST_VALID_BIT   = 2;
  localparam int ST_PM_LSB      = 4;
  localparam int RES_CHAN_LSB   = 12;
  localparam logic [1:0] CFG_RST = 2'h1;

  typedef enum logic {ADPP_PWR_UP, ADPP_PWR_DOWN} adpp_pwr_t;
  typedef enum logic [2:0] {H_IDLE, H_STROBE, H_RELEASE, H_WAIT_UP, H_CONV_RISE,
                            H_CONV_FALL} adpp_hstate_t;
endpackage

// File: adpp_port_if.sv
`timescale 1ns/1ps
interface adpp_port_if;
  import adpp_pkg::*;
  // Strobes, strap, conversion control and status.
  logic              cs_n;
  logic              rd_n;
  logic              wr_n;
  logic              conversion_start_n;
  logic              conversion_clock_in;
  logic              word_mode;
  logic              busy;
  // Two-way data pins; bit 8 is the shared_bit8_byte_select_pin.
  logic [DATA_W-1:0] dev_d_o;
  logic [DATA_W-1:0] dev_d_oe;
  logic [DATA_W-1:0] host_d_o;
  logic [DATA_W-1:0] host_d_oe;
  logic [DATA_W-1:0] db;

  // Resolved pin level; an undriven pin reads low as if pulled down.
  assign db = (dev_d_o & dev_d_oe) | (host_d_o & host_d_oe & ~dev_d_oe);

  modport dev (input cs_n, rd_n, wr_n, conversion_start_n, conversion_clock_in,
               word_mode, db, output busy, dev_d_o, dev_d_oe);
  modport host (output cs_n, rd_n, wr_n, conversion_start_n, conversion_clock_in,
                word_mode, host_d_o, host_d_oe, input busy, db);
endinterface

// File: adpp_read_fmt.sv
`timescale 1ns/1ps
module adpp_read_fmt
  import adpp_pkg::*;
  (
  // Mode and byte select.
  input  wire logic              word_mode,
  input  wire logic              high_byte_select,
  // Held result.
  input  wire logic [DATA_W-1:0] result,
  input  wire logic [CHAN_W-1:0] channel,
  // Pin image and the pins it may drive.
  output logic      [DATA_W-1:0] data,
  output logic      [DATA_W-1:0] mask
  );

  // Byte mode leaves the select pin to the host, so only the low byte is driven.
  always_comb begin
    data = '0;
    mask = '0;
    if (word_mode) begin
      data = result;
      mask = '1;
    end else begin
      mask[BYTE_W-1:0] = '1;
      if (high_byte_select) begin
        data[NIB_W-1:0]            = result[DATA_W-1:DATA_W-NIB_W];
        data[CHAN_LSB+:CHAN_W]     = channel;
      end else begin
        data[BYTE_W-1:0] = result[BYTE_W-1:0];
      end
    end
  end
endmodule

// File: adpp_dev_end.sv
`timescale 1ns/1ps
module adpp_dev_end
  import adpp_pkg::*;
  #(
  parameter bit TEN_BIT = 1'b0
  )
  (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Parallel port pins.
  adpp_port_if.dev               port,
  // Converter core: the value and channel a conversion produces.
  input  wire logic [DATA_W-1:0] sample_data,
  input  wire logic [CHAN_W-1:0] sample_channel,
  // Register contents seen by the core.
  output logic      [DATA_W-1:0] control_word,
  output logic      [BYTE_W-1:0] shadow_word,
  // Power and track-and-hold state.
  output logic      [1:0]        power_mode,
  output logic                   core_powered,
  output logic                   reference_powered,
  output logic                   tracking
  );

  logic              rd_act;
  logic              wr_act;
  logic              wr_act_q;
  logic              cst_q;
  logic              cclk_q;
  logic              wr_rise;
  logic              cst_fall;
  logic              cst_rise;
  logic              cclk_rise;
  logic              high_byte_select;
  logic              ctrl_done;
  logic              start;
  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] ctrl_new;
  logic [BYTE_W-1:0] shadow_q;
  logic              shadow_next_q;
  logic [DATA_W-1:0] result_q;
  logic [CHAN_W-1:0] chan_q;
  logic              busy_q;
  logic              done_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [1:0]        pm_cur;
  logic [1:0]        pm_new;
  logic [DATA_W-1:0] fmt_data;
  logic [DATA_W-1:0] fmt_mask;
  adpp_pwr_t         pwr_q;
  logic              track_q;

  // Strobes are combined as levels; edges come from the previous sample.
  assign rd_act           = !port.cs_n && !port.rd_n;
  assign wr_act           = !port.cs_n && !port.wr_n;
  assign wr_rise          = wr_act_q && !wr_act;
  assign cst_fall         = cst_q && !port.conversion_start_n;
  assign cst_rise         = !cst_q && port.conversion_start_n;
  assign cclk_rise        = !cclk_q && port.conversion_clock_in;
  assign high_byte_select = port.db[HB_SEL_BIT];

  // Sampled copies of the strobes for edge detection.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_act_q <= 1'b0;
      cst_q    <= 1'b1;
      cclk_q   <= 1'b0;
    end else begin
      wr_act_q <= wr_act;
      cst_q    <= port.conversion_start_n;
      cclk_q   <= port.conversion_clock_in;
    end
  end

  // Control word after the write now ending, built from the bytes on the pins.
  always_comb begin
    if (port.word_mode) begin
      ctrl_new = port.db;
    end else if (high_byte_select) begin
      ctrl_new = {port.db[NIB_W-1:0], ctrl_q[BYTE_W-1:0]};
    end else begin
      ctrl_new = {ctrl_q[DATA_W-1:BYTE_W], port.db[BYTE_W-1:0]};
    end
  end

  // A control write counts as complete on the word or on the high byte.
  assign ctrl_done = wr_rise && !shadow_next_q && (port.word_mode || high_byte_select);
  assign pm_cur    = {ctrl_q[PM_HI_BIT], ctrl_q[PM_LO_BIT]};
  assign pm_new    = {ctrl_new[PM_HI_BIT], ctrl_new[PM_LO_BIT]};

  // Control and shadow registers; a shadow request diverts the next write.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q        <= CTRL_RST;
      shadow_q      <= '0;
      shadow_next_q <= 1'b0;
    end else if (wr_rise) begin
      if (shadow_next_q) begin
        shadow_q      <= port.db[BYTE_W-1:0];
        shadow_next_q <= 1'b0;
      end else begin
        ctrl_q <= ctrl_new;
        if (ctrl_done) begin
          shadow_next_q <= ctrl_new[SHDW_BIT];
        end
      end
    end
  end

  // Conversion starts only when powered; the result is loaded one cycle before
  // busy falls so a bus held in read already shows it.
  assign start = cst_fall && !busy_q && (pwr_q == ADPP_PWR_UP);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      cnt_q    <= '0;
      result_q <= '0;
      chan_q   <= '0;
    end else if (start) begin
      busy_q <= 1'b1;
      cnt_q  <= '0;
    end else if (done_q) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (busy_q && cclk_rise) begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == CNT_W'(CONV_EDGES - 1)) begin
        done_q <= 1'b1;
        chan_q <= sample_channel;
        if (TEN_BIT) begin
          result_q <= {sample_data[DATA_W-PAD10_W-1:0], {PAD10_W{1'b0}}};
        end else begin
          result_q <= sample_data;
        end
      end
    end
  end

  // Power state and track-and-hold. Writes entering or leaving full shutdown take
  // priority over the conversion-end and start-edge events of the same cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_q   <= ADPP_PWR_UP;
      track_q <= 1'b0;
    end else if (ctrl_done && pm_new == PM_FULL_SD) begin
      pwr_q   <= ADPP_PWR_DOWN;
      track_q <= 1'b0;
    end else if (ctrl_done && pm_cur == PM_FULL_SD) begin
      pwr_q   <= ADPP_PWR_UP;
      track_q <= 1'b1;
    end else if (busy_q && done_q) begin
      if (pm_cur == PM_AUTO_SD || pm_cur == PM_AUTO_SB) begin
        pwr_q   <= ADPP_PWR_DOWN;
        track_q <= 1'b0;
      end else begin
        track_q <= 1'b1;
      end
    end else if (start) begin
      track_q <= 1'b0;
    end else if (cst_rise && pm_cur != PM_FULL_SD) begin
      pwr_q   <= ADPP_PWR_UP;
      track_q <= 1'b1;
    end
  end

  // Read path: the formatter picks word or byte, the strobes gate the drivers.
  adpp_read_fmt u_fmt (
    .word_mode        (port.word_mode),
    .high_byte_select (high_byte_select),
    .result           (result_q),
    .channel          (chan_q),
    .data             (fmt_data),
    .mask             (fmt_mask)
  );

  // Drivers drop the cycle the strobes rise, so the pins float again.
  assign port.dev_d_o  = fmt_data;
  assign port.dev_d_oe = rd_act ? fmt_mask : '0;
  assign port.busy     = busy_q;

  // Core-side views of the registers and power state.
  assign control_word      = ctrl_q;
  assign shadow_word       = shadow_q;
  assign power_mode        = pm_cur;
  assign core_powered      = (pwr_q == ADPP_PWR_UP);
  assign reference_powered = (pwr_q == ADPP_PWR_UP) || (pm_cur == PM_AUTO_SB);
  assign tracking          = track_q;
endmodule

// File: adpp_host_end.sv
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module adpp_host_end
  import adpp_pkg::*;
  #(
  parameter int SD_UP     = SD_UP_CYC,
  parameter int STROBE    = 2,
  parameter int CCLK_HALF = 2
  )
  (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Parallel port pins.
  adpp_port_if.host        port
  );

  adpp_hstate_t      st_q;
  logic [1:0]        cfg_q;
  logic [DATA_W-1:0] word_q;
  logic              shdw_q;
  logic              is_rd_q;
  logic              byte_q;
  logic [1:0]        pm_q;
  logic [WAIT_W-1:0] wait_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [DATA_W-1:0] res_q;
  logic [CHAN_W-1:0] chan_q;
  logic              valid_q;
  logic              cst_q;
  logic              cs_q;
  logic              rd_q;
  logic              wr_q;
  logic [DATA_W-1:0] d_q;
  logic [DATA_W-1:0] oe_q;
  logic [CNT_W-1:0]  div_q;
  logic              cclk_q;
  logic [31:0]       prd_q;
  logic              acc;
  logic              mapped;
  logic              two_bytes;

  assign acc       = psel && penable;
  assign mapped    = paddr == REG_CFG || paddr == REG_CMD_WR || paddr == REG_CMD_CONV ||
                     paddr == REG_STATUS || paddr == REG_RESULT;
  assign two_bytes = !cfg_q[CFG_WORD_BIT] && !shdw_q && !byte_q;
  assign pready    = 1'b1;
  assign pslverr   = acc && !mapped;
  assign prdata    = prd_q;

  // Read data is fetched in the setup cycle so it comes from a flop.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prd_q <= '0;
    end else if (psel && !penable) begin
      prd_q <= '0;
      unique case (paddr)
        REG_CFG:    prd_q[1:0] <= cfg_q;
        REG_STATUS: prd_q[ST_PM_LSB+:2] <= pm_q;
        REG_RESULT: prd_q[RES_CHAN_LSB+:CHAN_W] <= chan_q;
        default:    prd_q <= '0;
      endcase
      if (paddr == REG_STATUS) begin
        prd_q[ST_SEQ_BIT]   <= st_q != H_IDLE;
        prd_q[ST_BUSY_BIT]  <= port.busy;
        prd_q[ST_VALID_BIT] <= valid_q;
      end
      if (paddr == REG_RESULT) begin
        prd_q[DATA_W-1:0] <= res_q;
      end
    end
  end

  // Free-running conversion clock from an enable divider.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q  <= '0;
      cclk_q <= 1'b0;
    end else if (div_q == CNT_W'(CCLK_HALF - 1)) begin
      div_q  <= '0;
      cclk_q <= !cclk_q;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Transfer and conversion sequencer; commands arriving while busy are dropped.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= H_IDLE;
      cfg_q <= CFG_RST;
      word_q <= '0;
      shdw_q <= 1'b0;
      is_rd_q <= 1'b0;
      byte_q <= 1'b0;
      pm_q <= PM_NORMAL;
      wait_q <= '0;
      cnt_q <= '0;
      res_q <= '0;
      chan_q <= '0;
      valid_q <= 1'b0;
      cst_q <= 1'b1;
      cs_q <= 1'b1;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      d_q <= '0;
      oe_q <= '0;
    end else begin
      if (wait_q != '0 && st_q != H_WAIT_UP) begin
        wait_q <= wait_q - 1'b1;
      end
      if (acc && pwrite && paddr == REG_CFG) begin
        cfg_q <= pwdata[1:0];
      end
      unique case (st_q)
        H_IDLE: begin
          byte_q <= 1'b0;
          if (acc && pwrite && paddr == REG_CMD_WR) begin
            word_q  <= pwdata[DATA_W-1:0];
            shdw_q  <= pwdata[CMD_SHDW_BIT];
            is_rd_q <= 1'b0;
            cs_q    <= 1'b0;
            wr_q    <= 1'b0;
            oe_q    <= cfg_q[CFG_WORD_BIT] ? '1 : {{NIB_W-1{1'b0}}, {BYTE_W+1{1'b1}}};
            d_q     <= cfg_q[CFG_WORD_BIT] && !pwdata[CMD_SHDW_BIT] ?
                       pwdata[DATA_W-1:0] : {{NIB_W{1'b0}}, pwdata[BYTE_W-1:0]};
            cnt_q   <= CNT_W'(STROBE - 1);
            st_q    <= H_STROBE;
          end else if (acc && pwrite && paddr == REG_CMD_CONV) begin
            // Start is raised in every mode: an auto mode leaves it low, and
            // without a high level first the start fall would never come.
            valid_q <= 1'b0;
            cst_q   <= 1'b1;
            st_q    <= H_WAIT_UP;
            if (pm_q == PM_AUTO_SD) begin
              wait_q <= WAIT_W'(SD_UP);
            end else if (pm_q == PM_AUTO_SB) begin
              wait_q <= cfg_q[CFG_INTREF_BIT] ? WAIT_W'(SB_INT_CYC) : WAIT_W'(SB_EXT_CYC);
            end
          end
        end
        H_STROBE: begin
          if (cnt_q == '0) begin
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            st_q <= H_RELEASE;
            if (is_rd_q) begin
              if (cfg_q[CFG_WORD_BIT]) begin
                res_q <= port.db;
              end else if (byte_q) begin
                res_q[DATA_W-1:BYTE_W] <= port.db[NIB_W-1:0];
                chan_q <= port.db[CHAN_LSB+:CHAN_W];
              end else begin
                res_q[BYTE_W-1:0] <= port.db[BYTE_W-1:0];
              end
            end
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        H_RELEASE: begin
          cs_q  <= 1'b1;
          oe_q  <= '0;
          cnt_q <= CNT_W'(STROBE - 1);
          if (two_bytes || (is_rd_q && !cfg_q[CFG_WORD_BIT] && !byte_q)) begin
            byte_q <= 1'b1;
            cs_q   <= 1'b0;
            st_q   <= H_STROBE;
            if (is_rd_q) begin
              rd_q <= 1'b0;
              oe_q[HB_SEL_BIT] <= 1'b1;
              d_q  <= '0;
              d_q[HB_SEL_BIT] <= 1'b1;
            end else begin
              wr_q <= 1'b0;
              oe_q <= {{NIB_W-1{1'b0}}, {BYTE_W+1{1'b1}}};
              d_q  <= {{NIB_W-1{1'b0}}, 1'b1, {NIB_W{1'b0}}, word_q[DATA_W-1:BYTE_W]};
            end
          end else begin
            st_q <= H_IDLE;
            if (is_rd_q) begin
              valid_q <= 1'b1;
            end else if (!shdw_q) begin
              pm_q <= {word_q[PM_HI_BIT], word_q[PM_LO_BIT]};
              if (pm_q == PM_FULL_SD && word_q[PM_HI_BIT:PM_LO_BIT] != PM_FULL_SD) begin
                wait_q <= WAIT_W'(SD_UP);
              end
            end
          end
        end
        H_WAIT_UP: begin
          if (wait_q != '0) begin
            wait_q <= wait_q - 1'b1;
          end else if (pm_q != PM_FULL_SD) begin
            cst_q <= 1'b0;
            st_q  <= H_CONV_RISE;
          end else begin
            st_q <= H_IDLE;
          end
        end
        H_CONV_RISE: begin
          if (port.busy) begin
            st_q <= H_CONV_FALL;
          end
        end
        H_CONV_FALL: begin
          if (!port.busy) begin
            cst_q   <= pm_q == PM_NORMAL;
            is_rd_q <= 1'b1;
            shdw_q  <= 1'b0;
            cs_q    <= 1'b0;
            rd_q    <= 1'b0;
            cnt_q   <= CNT_W'(STROBE - 1);
            oe_q    <= '0;
            d_q     <= '0;
            oe_q[HB_SEL_BIT] <= !cfg_q[CFG_WORD_BIT];
            st_q    <= H_STROBE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Pins come straight from flops.
  assign port.cs_n                = cs_q;
  assign port.rd_n                = rd_q;
  assign port.wr_n                = wr_q;
  assign port.conversion_start_n  = cst_q;
  assign port.conversion_clock_in = cclk_q;
  assign port.word_mode           = cfg_q[CFG_WORD_BIT];
  assign port.host_d_o            = d_q;
  assign port.host_d_oe           = oe_q;
endmodule

// File: adpp_monitor.sv
`timescale 1ns/1ps
module adpp_monitor
  import adpp_pkg::*;
  (
  // Clock and reset.
  input wire logic              clk,
  input wire logic              sys_rst,
  // Strobes, strap and status.
  input wire logic              cs_n,
  input wire logic              rd_n,
  input wire logic              wr_n,
  input wire logic              conversion_start_n,
  input wire logic              conversion_clock_in,
  input wire logic              word_mode,
  input wire logic              busy,
  // Data pins.
  input wire logic [DATA_W-1:0] dev_d_oe,
  input wire logic [DATA_W-1:0] host_d_oe,
  input wire logic [DATA_W-1:0] db
  );
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic       cc_q;
  logic [4:0] rise_q;
  wire        rd_on = !cs_n && !rd_n;

  // Conversion clock rises since the last start; it saturates so a stray count never wraps.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cc_q <= 1'b0;
      rise_q <= 5'h00;
    end else begin
      cc_q <= conversion_clock_in;
      if ($fell(conversion_start_n)) begin
        rise_q <= 5'h00;
      end else if (conversion_clock_in && !cc_q && rise_q != 5'h1f) begin
        rise_q <= rise_q + 5'h01;
      end
    end
  end

  drive_in_read_a: assert property ((dev_d_oe != 12'h000) |-> rd_on)
    else $error("device drives the bus outside a read");
  word_read_a: assert property ((rd_on && word_mode) |-> dev_d_oe == 12'hfff)
    else $error("word read does not drive all pins");
  byte_read_a: assert property ((rd_on && !word_mode) |->
    (dev_d_oe[11:8] == 4'h0 && dev_d_oe[3:0] == 4'hf))
    else $error("byte read drives the wrong pins");
  low_byte_a: assert property ((rd_on && !word_mode && !db[8]) |-> dev_d_oe[7:4] == 4'hf)
    else $error("low byte read leaves pins undriven");
  high_byte_a: assert property ((rd_on && !word_mode && db[8]) |-> dev_d_oe[7:5] == 3'h7)
    else $error("high byte read leaves channel pins undriven");
  read_release_a: assert property ($rose(rd_n) |-> dev_d_oe == 12'h000)
    else $error("bus not released at end of read");
  no_contention_a: assert property ((dev_d_oe & host_d_oe) == 12'h000)
    else $error("both ends drive the same pin");
  hb_top_zero_a: assert property ((!cs_n && !wr_n && !word_mode && db[8]) |->
    db[7:4] == 4'h0)
    else $error("high byte write with nonzero top bits");
  wr_hold_a: assert property (($rose(wr_n) && !cs_n) |-> host_d_oe != 12'h000)
    else $error("write data gone at strobe rise");
  busy_start_a: assert property (($fell(conversion_start_n) && !busy) |=> busy)
    else $error("busy did not rise after start");
  conv_len_a: assert property ($fell(busy) |-> rise_q == 5'(CONV_EDGES))
    else $error("conversion length wrong");
endmodule

// File: adc_parallel_port_power_modes_tb_top.sv
`timescale 1ns/1ps
module adc_parallel_port_power_modes_tb_top;
  import adpp_pkg::*;
  logic              clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, cp, rp, trk;
  logic [7:0]        paddr, sw;
  logic [31:0]       pwdata, prdata, rd;
  logic [DATA_W-1:0] sdat, cw;
  logic [CHAN_W-1:0] schan;
  logic [1:0]        pm;
  int                n_mismatch, checked, cyc, hi_n, last_hi;
  localparam int     TB_SD_UP = 40;

  adpp_port_if port ();
  adpp_dev_end #(.TEN_BIT(1'b0)) adpp_dev_end_i (.clk(clk), .sys_rst(sys_rst),
    .port(port.dev), .sample_data(sdat), .sample_channel(schan), .control_word(cw),
    .shadow_word(sw), .power_mode(pm), .core_powered(cp), .reference_powered(rp),
    .tracking(trk));
  adpp_host_end #(.SD_UP(TB_SD_UP)) adpp_host_end_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port(port.host));
  adpp_monitor adpp_monitor_i (.clk(clk), .sys_rst(sys_rst), .cs_n(port.cs_n),
    .rd_n(port.rd_n), .wr_n(port.wr_n), .conversion_start_n(port.conversion_start_n),
    .conversion_clock_in(port.conversion_clock_in), .word_mode(port.word_mode),
    .busy(port.busy), .dev_d_oe(port.dev_d_oe), .host_d_oe(port.host_d_oe), .db(port.db));

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  // Length in cycles of the last high stretch of start, for the wake-time checks.
  always @(posedge clk) begin
    if (port.conversion_start_n) begin
      hi_n <= hi_n + 1;
    end else if (hi_n != 0) begin
      last_hi <= hi_n;
      hi_n    <= 0;
    end
  end

  // Cycle ceiling; the whole run needs well under a thousand cycles, so a hang ends here.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle cycle follows so the next setup never lands in the same step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Polls status until the controller's sequencer has finished; a hang ends at the ceiling.
  task automatic idle();
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
    end while (rd[ST_SEQ_BIT] !== 1'b0);
  endtask

  task automatic wr_ctrl(input logic [11:0] v);
    apb(1'b1, REG_CMD_WR, {20'h0, v});
    idle();
  endtask

  // Converts with a known core value and leaves the result in rd.
  task automatic conv(input logic [11:0] d, input logic [2:0] c);
    sdat <= d;
    schan <= c;
    apb(1'b1, REG_CMD_CONV, 32'h0);
    idle();
    apb(1'b0, REG_RESULT, 32'h0);
  endtask

  task automatic t_reset();
    chk(pm, PM_NORMAL);
    chk(trk, 1'b0);
    apb(1'b0, REG_CFG, 32'h0);
    chk(rd, 32'(CFG_RST));
  endtask

  task automatic t_word();
    wr_ctrl(12'h2a5);
    chk(cw, 12'h2a5);
    conv(12'hc3a, 3'h6);
    chk(rd[11:0], 12'hc3a);
    chk(trk, 1'b1);
  endtask

  task automatic t_shadow();
    wr_ctrl(12'h008);
    apb(1'b1, REG_CMD_WR, 32'h0001_005a);
    idle();
    chk(sw, 8'h5a);
    chk(cw, 12'h008);
  endtask

  task automatic t_byte();
    apb(1'b1, REG_CFG, 32'h0);
    wr_ctrl(12'h1c3);
    chk(cw, 12'h1c3);
    conv(12'hb6d, 3'h5);
    chk(rd[11:0], 12'hb6d);
    chk(rd[14:12], 3'h5);
  endtask

  // Full shutdown follows the write; auto modes power down after each conversion.
  task automatic t_power();
    wr_ctrl(12'hc00);
    chk(cp, 1'b0);
    chk(trk, 1'b0);
    wr_ctrl(12'h000);
    chk(cp, 1'b1);
    chk(trk, 1'b1);
    conv(12'h0f0, 3'h7);
    chk(rd[11:0], 12'h0f0);
    for (int m = 1; m < 3; m++) begin
      wr_ctrl({m[1:0], 10'h000});
      chk(pm, 32'(m));
      conv(12'h5a5, 3'h2);
      chk(rd[11:0], 12'h5a5);
      chk(cp, 1'b0);
      chk(rp, 32'(m == 2));
      chk(trk, 1'b0);
      chk(cw, {m[1:0], 10'h000});
      chk(port.conversion_start_n, 1'b0);
      chk(32'(last_hi >= (m == 1 ? TB_SD_UP : SB_EXT_CYC)), 32'h1);
    end
    // Back to normal from standby: the start rise must wake the core.
    wr_ctrl(12'h000);
    conv(12'h3c7, 3'h1);
    chk(rd[11:0], 12'h3c7);
    chk(rd[14:12], 3'h1);
    chk(cp, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sdat = 12'h000;
    schan = 3'h0;
    n_mismatch = 0;
    checked = 0;
    cyc = 0;
    hi_n = 0;
    last_hi = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_word();
    t_shadow();
    t_byte();
    t_power();
    end_of_test();
  end
endmodule
